// ---- rtl/sfs_spi_front.v ----
// How it works
// - Three address bytes taken; top seven bits dropped, low 17 select the byte.
// - Clock level at select fall picks mode 0 or mode 3.
// - Input sampled on clock rise, output changed on clock fall.
// - Mode 3 ignores the idle-high level; first real rise counts.
// - First byte after select is the opcode; one opcode per select.
// - Deselected device ignores input and tristates output.
// - All bytes move most significant bit first.
// - Unknown opcode ignored, input ignored until reselect, output off.
// - Latch set command is 0x06.
// - Latch clear command is 0x04.
// - Eight-bit status, read by 0x05, written by 0x01.
// - Memory read 0x03, fast read 0x0B, memory write 0x02.
// - Sleep 0xB9, ident 0x9F, serial number 0xC3; ten opcodes.
// - Latch clear after reset; writes refused until set.
// - Status write data never sets the latch flag; the select rise after it clears the flag.
// - Select rise after clear, status write or memory write clears latch.
// - Latch clear blocks writes; status read then shows flag zero.
// - Each byte write is queued in the write buffer and reaches the array when it is ready, unless the buffer stays full until the next byte; never busy.
// - Latch flag sits in status bit 1.
// - Status bits 0,4,5 read zero, bit 6 reads one; not writable.
// - Burst address increments per byte and wraps to zero.
`include "sfs_consts.vh"
module sfs_spi_front #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire core_clk,
  input wire srst,
  input wire cs_n_pin,
  input wire sck_pin,
  input wire si_pin,
  output reg so_out_ff,
  output reg so_oe_ff,
  input wire [7:0] rd_data,
  output reg wr_valid_ff,
  output reg [16:0] wr_addr_ff,
  output reg [7:0] wr_data_ff,
  input wire wr_ready,
  output reg rd_req_ff,
  output reg [16:0] rd_addr_ff,
  output reg [7:0] cmd_ff,
  output reg cmd_strobe_ff,
  output reg [7:0] status_ff,
  output reg spi_mode3_ff
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_OPC = 6'b000010;
  localparam ST_ADDR = 6'b000100;
  localparam ST_DATA = 6'b001000;
  localparam ST_SKIP = 6'b010000;
  localparam ST_DONE = 6'b100000;

  // Three-stage pin synchronisers
  reg [2:0] cs_sync_ff;
  reg [2:0] sck_sync_ff;
  reg [2:0] si_sync_ff;
  reg cs_n_ff;
  reg sck_ff;
  reg si_ff;
  reg [5:0] state_ff;
  reg [2:0] bit_cnt_ff;
  reg [1:0] addr_cnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] opcode_ff;
  reg [23:0] addr_sh_ff;
  reg [16:0] addr_ff;
  reg [7:0] tx_ff;
  reg latch_ff;
  reg [7:0] cfg_ff;
  reg armed_ff;
  reg write_op_ff;
  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;
  wire [7:0] nxt_shift;
  wire byte_done;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [24:0] fifo_out_data;
  reg fifo_push;
  reg [24:0] fifo_in_data;
  reg op_valid;
  reg op_has_addr;

  // Change accepted once stages two and three agree
  always @(posedge core_clk) begin
    if (srst) begin
      cs_sync_ff <= 3'h7;
      sck_sync_ff <= 3'h0;
      si_sync_ff <= 3'h0;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      si_ff <= 1'b0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], cs_n_pin};
      sck_sync_ff <= {sck_sync_ff[1:0], sck_pin};
      si_sync_ff <= {si_sync_ff[1:0], si_pin};
      if (cs_sync_ff[1] == cs_sync_ff[2]) begin
        cs_n_ff <= cs_sync_ff[2];
      end
      if (sck_sync_ff[1] == sck_sync_ff[2]) begin
        sck_ff <= sck_sync_ff[2];
      end
      if (si_sync_ff[1] == si_sync_ff[2]) begin
        si_ff <= si_sync_ff[2];
      end
    end
  end

  // Edges are taken where stages two and three agree and differ from the filtered stage
  assign sck_rise = (sck_sync_ff[1] == sck_sync_ff[2]) & sck_sync_ff[2] & ~sck_ff;
  assign sck_fall = (sck_sync_ff[1] == sck_sync_ff[2]) & ~sck_sync_ff[2] & sck_ff;
  assign cs_fall = (cs_sync_ff[1] == cs_sync_ff[2]) & ~cs_sync_ff[2] & cs_n_ff;
  assign cs_rise = (cs_sync_ff[1] == cs_sync_ff[2]) & cs_sync_ff[2] & ~cs_n_ff;
  assign nxt_shift = {shift_ff[6:0], si_ff};
  assign byte_done = sck_rise & (bit_cnt_ff == 3'h7);

  always @* begin
    op_valid = 1'b1;
    op_has_addr = 1'b0;
    case (nxt_shift)
      `SFS_OP_LATCH_SET: op_valid = 1'b1;
      `SFS_OP_LATCH_CLEAR: op_valid = 1'b1;
      `SFS_OP_STATUS_READ: op_valid = 1'b1;
      `SFS_OP_STATUS_WRITE: op_valid = 1'b1;
      `SFS_OP_MEM_READ: op_has_addr = 1'b1;
      `SFS_OP_FAST_READ: op_has_addr = 1'b1;
      `SFS_OP_MEM_WRITE: op_has_addr = 1'b1;
      `SFS_OP_SLEEP: op_valid = 1'b1;
      `SFS_OP_IDENT_READ: op_valid = 1'b1;
      `SFS_OP_SERIAL_NUMBER_READ: op_valid = 1'b1;
      default: op_valid = 1'b0;
    endcase
  end

  // Main transaction engine
  always @(posedge core_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 3'h0;
      addr_cnt_ff <= 2'h0;
      shift_ff <= 8'h00;
      opcode_ff <= 8'h00;
      addr_sh_ff <= 24'h000000;
      addr_ff <= 17'h00000;
      tx_ff <= 8'h00;
      latch_ff <= 1'b0;
      cfg_ff <= 8'h00;
      armed_ff <= 1'b0;
      write_op_ff <= 1'b0;
      spi_mode3_ff <= 1'b0;
      so_out_ff <= 1'b0;
      so_oe_ff <= 1'b0;
      fifo_push <= 1'b0;
      fifo_in_data <= 25'h0000000;
      rd_req_ff <= 1'b0;
      rd_addr_ff <= 17'h00000;
      cmd_ff <= 8'h00;
      cmd_strobe_ff <= 1'b0;
    end else begin
      cmd_strobe_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      if (fifo_push & fifo_in_ready) begin
        fifo_push <= 1'b0;
      end
      if (cs_rise) begin
        so_oe_ff <= 1'b0;
        state_ff <= ST_IDLE;
        if (write_op_ff) begin
          latch_ff <= 1'b0;
        end
        write_op_ff <= 1'b0;
      end else if (cs_fall) begin
        spi_mode3_ff <= sck_ff;
        // idle-high level is not a rise
        armed_ff <= 1'b1;
        state_ff <= ST_OPC;
        bit_cnt_ff <= 3'h0;
        addr_cnt_ff <= 2'h0;
      end else if (~cs_n_ff & armed_ff) begin
        if (sck_rise & (state_ff != ST_SKIP) & (state_ff != ST_IDLE)) begin
          shift_ff <= nxt_shift;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
        if (sck_fall & so_oe_ff) begin
          so_out_ff <= tx_ff[7];
          tx_ff <= {tx_ff[6:0], 1'b0};
        end
        if (byte_done) begin
          case (state_ff)
            ST_OPC: begin
              opcode_ff <= nxt_shift;
              cmd_ff <= nxt_shift;
              cmd_strobe_ff <= op_valid;
              if (~op_valid) begin
                state_ff <= ST_SKIP;
              end else if (op_has_addr) begin
                state_ff <= ST_ADDR;
              end else if (nxt_shift == `SFS_OP_STATUS_READ) begin
                tx_ff <= status_ff;
                so_oe_ff <= 1'b1;
                state_ff <= ST_DATA;
              end else if (nxt_shift == `SFS_OP_LATCH_SET) begin
                latch_ff <= 1'b1;
                state_ff <= ST_DONE;
              end else if (nxt_shift == `SFS_OP_LATCH_CLEAR) begin
                write_op_ff <= 1'b1;
                state_ff <= ST_DONE;
              end else if (nxt_shift == `SFS_OP_STATUS_WRITE) begin
                write_op_ff <= 1'b1;
                state_ff <= ST_DATA;
              end else begin
                // Sleep, ident and serial number belong elsewhere
                state_ff <= ST_DONE;
              end
            end
            ST_ADDR: begin
              addr_sh_ff <= {addr_sh_ff[15:0], nxt_shift};
              addr_cnt_ff <= addr_cnt_ff + 2'h1;
              if (addr_cnt_ff == 2'h2) begin
                addr_ff <= {addr_sh_ff[8:0], nxt_shift};
                if (opcode_ff == `SFS_OP_MEM_WRITE) begin
                  write_op_ff <= 1'b1;
                  state_ff <= ST_DATA;
                end else if (opcode_ff == `SFS_OP_FAST_READ) begin
                  // Fast read spends one dummy byte here
                  state_ff <= ST_DONE;
                  rd_req_ff <= 1'b1;
                  rd_addr_ff <= {addr_sh_ff[8:0], nxt_shift};
                end else begin
                  rd_req_ff <= 1'b1;
                  rd_addr_ff <= {addr_sh_ff[8:0], nxt_shift};
                  state_ff <= ST_DATA;
                end
              end
            end
            ST_DONE: begin
              if (opcode_ff == `SFS_OP_FAST_READ) begin
                state_ff <= ST_DATA;
                tx_ff <= rd_data;
                so_oe_ff <= 1'b1;
                // First byte after the dummy is the start address itself,
                // so the dummy byte must not advance the pointer
                rd_addr_ff <= addr_ff;
                rd_req_ff <= 1'b1;
              end
            end
            ST_DATA: begin
              if (opcode_ff == `SFS_OP_STATUS_WRITE) begin
                if (latch_ff) begin
                  cfg_ff <= nxt_shift & `SFS_ST_WRITE_MASK;
                end
              end else if (opcode_ff == `SFS_OP_MEM_WRITE) begin
                if (latch_ff) begin
                  fifo_push <= 1'b1;
                  fifo_in_data <= {addr_ff, nxt_shift};
                end
                addr_ff <= (addr_ff == `SFS_ADDR_LAST) ? 17'h00000 : addr_ff + 17'h00001;
              end else if (opcode_ff != `SFS_OP_STATUS_READ) begin
                tx_ff <= rd_data;
                addr_ff <= (addr_ff == `SFS_ADDR_LAST) ? 17'h00000 : addr_ff + 17'h00001;
                rd_addr_ff <= (addr_ff == `SFS_ADDR_LAST) ? 17'h00000 : addr_ff + 17'h00001;
                rd_req_ff <= 1'b1;
              end else begin
                // Status read repeats the same byte
                tx_ff <= status_ff;
              end
            end
            default: state_ff <= state_ff;
          endcase
        end else if ((state_ff == ST_DATA) & (bit_cnt_ff == 3'h0) & rd_req_ff) begin
          // Each read byte loaded once the array answers
          tx_ff <= rd_data;
          so_oe_ff <= 1'b1;
        end
      end
    end
  end

  // fixed bits forced, only WPEN and BP writable
  always @(posedge core_clk) begin
    if (srst) begin
      status_ff <= `SFS_ST_RESET;
    end else begin
      status_ff <= cfg_ff | `SFS_ST_RESET | {6'h00, latch_ff, 1'b0};
    end
  end

  // Write path buffer absorbs array back-pressure
  sfs_fifo #(
    .WIDTH(25),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_wr_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_data(fifo_in_data),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(wr_ready & ~wr_valid_ff)
  );

  // Registered write port toward the array
  always @(posedge core_clk) begin
    if (srst) begin
      wr_valid_ff <= 1'b0;
      wr_addr_ff <= 17'h00000;
      wr_data_ff <= 8'h00;
    end else if (fifo_out_valid & wr_ready & ~wr_valid_ff) begin
      wr_valid_ff <= 1'b1;
      wr_addr_ff <= fifo_out_data[24:8];
      wr_data_ff <= fifo_out_data[7:0];
    end else begin
      wr_valid_ff <= 1'b0;
    end
  end
endmodule

// ---- rtl/sfs_consts.vh ----
`ifndef SFS_CONSTS_VH
`define SFS_CONSTS_VH
// Opcodes
`define SFS_OP_LATCH_SET 8'h06
`define SFS_OP_LATCH_CLEAR 8'h04
`define SFS_OP_STATUS_READ 8'h05
`define SFS_OP_STATUS_WRITE 8'h01
`define SFS_OP_MEM_READ 8'h03
`define SFS_OP_FAST_READ 8'h0B
`define SFS_OP_MEM_WRITE 8'h02
`define SFS_OP_SLEEP 8'hB9
`define SFS_OP_IDENT_READ 8'h9F
`define SFS_OP_SERIAL_NUMBER_READ 8'hC3
// Status register fields
`define SFS_ST_LATCH_BIT 1
`define SFS_ST_BP_LO 2
`define SFS_ST_BP_HI 3
`define SFS_ST_ONE_BIT 6
`define SFS_ST_WPEN_BIT 7
`define SFS_ST_RESET 8'h40
`define SFS_ST_WRITE_MASK 8'h8C
// Address layout
`define SFS_ADDR_BITS 17
`define SFS_ADDR_LAST 17'h1FFFF
`define SFS_ADDR_BYTES 3
`endif

// ---- rtl/sfs_fifo.v ----
// Small flip-flop FIFO, valid/ready on both sides
module sfs_fifo #(
  parameter WIDTH = 25,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire core_clk,
  input wire srst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  // Honest flags from the occupancy count
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap at DEPTH, which is a power of two
  always @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push & ~pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop & ~push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // Storage has no reset; only written slots are ever read
  always @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule

// ---- verification/sfs_spi_front_properties.sv ----
`include "sfs_consts.vh"
module sfs_spi_front_properties (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic so_out_ff,
  input wire logic so_oe_ff,
  input wire logic wr_valid_ff,
  input wire logic [16:0] wr_addr_ff,
  input wire logic rd_req_ff,
  input wire logic [7:0] cmd_ff,
  input wire logic cmd_strobe_ff,
  input wire logic [7:0] status_ff,
  input wire logic spi_mode3_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_oe_off_idle: assert property (cs_n_pin [*5] |-> !so_oe_ff)
    else $error("output enabled while deselected");
  a_strobe_single: assert property (cmd_strobe_ff |=> !cmd_strobe_ff)
    else $error("opcode strobe longer than one cycle");
  a_status_fixed: assert property (status_ff[6] && status_ff[5:4] == 2'h0 && !status_ff[0])
    else $error("fixed status bits wrong");
  a_mode_steady: assert property (!cs_n_pin [*8] |=> cs_n_pin || $stable(spi_mode3_ff))
    else $error("mode changed inside a frame");
  a_latch_set_src: assert property ($rose(status_ff[1]) |-> cmd_ff == `SFS_OP_LATCH_SET)
    else $error("latch set by another opcode");
  a_latch_clr_src: assert property ($fell(status_ff[1]) |-> cmd_ff inside {8'h04, 8'h01, 8'h02})
    else $error("latch cleared by another opcode");
  a_oe_reads_only: assert property (so_oe_ff |-> cmd_ff inside {8'h05, 8'h03, 8'h0B, 8'h9F, 8'hC3})
    else $error("output driven outside a read");
  a_strobe_valid: assert property (cmd_strobe_ff |-> ##[0:1] cmd_ff inside {8'h06, 8'h04, 8'h05,
    8'h01, 8'h03, 8'h0B, 8'h02, 8'hB9, 8'h9F, 8'hC3}) else $error("strobe on unknown opcode");
  a_so_on_fall: assert property ($changed(so_out_ff) && so_oe_ff && $past(so_oe_ff) |-> !$past(sck_pin, 3))
    else $error("output moved away from clock fall");
  a_rdreq_in_read: assert property (rd_req_ff |-> cmd_ff inside {8'h03, 8'h0B})
    else $error("array read requested outside a memory read");
  a_wr_pulse: assert property (wr_valid_ff |=> !wr_valid_ff)
    else $error("array write pulse longer than one cycle");
  c_mem_write: cover property (cmd_strobe_ff && cmd_ff == 8'h02);
  c_wrap: cover property (wr_valid_ff && wr_addr_ff == 17'h00000);
  c_read_mode3: cover property (so_oe_ff && spi_mode3_ff);
endmodule
bind sfs_spi_front sfs_spi_front_properties u_props (.*);

// ---- verification/sfs_spi_master.sv ----
module sfs_spi_master (
  input wire logic core_clk,
  input wire logic so_out_ff,
  input wire logic so_oe_ff,
  output logic cs_n_pin,
  output logic sck_pin,
  output logic si_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;
  logic last_so = 1'b0;
  logic mode3 = 1'b0;
  // Released line shows the inverse so stale data never matches
  wire so_line = so_oe_ff ? so_out_ff : ~last_so;
  initial begin
    cs_n_pin = 1'b1;
    sck_pin = 1'b0;
    si_pin = 1'b0;
  end
  always @(posedge core_clk) begin
    if (so_oe_ff) last_so <= so_out_ff;
  end
  // Data line wanders outside frames
  always @(posedge core_clk) begin
    if (cs_n_pin) si_pin <= ~si_pin;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic sel(input logic m3);
    mode3 = m3;
    tick(1);
    sck_pin = m3;
    tick(HALF);
    cs_n_pin = 1'b0;
    tick(HALF);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_pin = 1'b0;
      si_pin = tx[i];
      tick(HALF);
      sck_pin = 1'b1;
      rx[i] = so_line;
      tick(HALF);
      if (!mode3) sck_pin = 1'b0;
    end
  endtask
  task automatic desel();
    tick(HALF);
    cs_n_pin = 1'b1;
    tick(12);
  endtask
endmodule

// ---- verification/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic wr_ready = 1'b1;
  logic stall = 1'b0;
  int oe_cnt = 0;
  int oe_mark = 0;
  logic m;
  logic cs_n_pin, sck_pin, si_pin, so_out_ff, so_oe_ff, wr_valid_ff, rd_req_ff, cmd_strobe_ff, spi_mode3_ff;
  logic [7:0] wr_data_ff, cmd_ff, status_ff, rx;
  logic [16:0] wr_addr_ff, rd_addr_ff;
  logic [7:0] mem [0:131071];
  logic [7:0] d [4];
  logic [7:0] ops [10] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0B, 8'h02, 8'hB9, 8'h9F, 8'hC3};
  int miscompares = 0;
  int num_checks = 0;
  wire [7:0] rd_data = mem[rd_addr_ff];
  sfs_spi_front u_sfs_spi_front (.*);
  sfs_spi_master u_sfs_spi_master (.*);
  initial forever #2 core_clk = ~core_clk;
  // Array model; random back-pressure keeps the buffer busy
  always @(posedge core_clk) begin
    if (wr_valid_ff) mem[wr_addr_ff] <= wr_data_ff;
    wr_ready <= #1 !stall && ($urandom % 4 != 0);
    if (so_oe_ff) oe_cnt <= oe_cnt + 1;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Background pattern of the array model
  function automatic logic [7:0] fill(input int a);
    fill = a[7:0] ^ 8'h5A;
  endfunction
  // Status image: bit 6 fixed one, flag at bit 1, only bits 7,3,2 writable
  function automatic logic [7:0] exp_status(input logic latch, input logic [7:0] cfg);
    exp_status = (cfg & 8'h8C) | 8'h40 | {6'h00, latch, 1'b0};
  endfunction
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] op);
    m = $urandom % 2;
    u_sfs_spi_master.sel(m);
    u_sfs_spi_master.xfer(op, rx);
  endtask
  task automatic cmd1(input logic [7:0] op);
    frame(op);
    u_sfs_spi_master.desel();
  endtask
  task automatic send(input logic [7:0] b);
    u_sfs_spi_master.xfer(b, rx);
  endtask
  task automatic rd_status(input logic [7:0] exp);
    frame(8'h05);
    chk("mode", {7'h00, m}, {7'h00, spi_mode3_ff});
    send(8'h00);
    chk("status", exp, rx);
    u_sfs_spi_master.desel();
  endtask
  task automatic mem_op(input logic [7:0] op, input logic [16:0] a);
    frame(op);
    // unused address bits sent as zero
    send({7'h00, a[16]});
    send(a[15:8]);
    send(a[7:0]);
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    $display("[ERR] watchdog expected finish seen hang");
    conclude();
  end
  initial begin
    void'($urandom(32'hAC43));
    for (int i = 0; i < 131072; i++) mem[i] = fill(i);
    repeat (4) @(posedge core_clk);
    #1 srst = 1'b0;
    repeat (8) @(posedge core_clk);
    rd_status(exp_status(1'b0, 8'h00));
    mem_op(8'h02, 17'h00010);
    send(8'hA5);
    u_sfs_spi_master.desel();
    chk("locked mem", fill(32'h00000010), mem[17'h00010]);
    $display("test reset_lock done");
    cmd1(8'h06);
    rd_status(exp_status(1'b1, 8'h00));
    frame(8'h01);
    send(8'hFF);
    u_sfs_spi_master.desel();
    rd_status(exp_status(1'b0, 8'hFF));
    cmd1(8'h06);
    frame(8'h01);
    send(8'h00);
    u_sfs_spi_master.desel();
    cmd1(8'h06);
    cmd1(8'h04);
    rd_status(8'h40);
    $display("test status_latch done");
    cmd1(8'h06);
    stall = 1'b1;
    mem_op(8'h02, 17'h1FFFE);
    for (int i = 0; i < 4; i++) begin
      d[i] = $urandom;
      send(d[i]);
      if (i == 2) stall = 1'b0;
    end
    u_sfs_spi_master.desel();
    chk("wr 1FFFE", d[0], mem[17'h1FFFE]);
    chk("wr 1FFFF", d[1], mem[17'h1FFFF]);
    chk("wr 00000", d[2], mem[17'h00000]);
    chk("wr 00001", d[3], mem[17'h00001]);
    rd_status(8'h40);
    mem_op(8'h03, 17'h1FFFF);
    send(8'h00);
    chk("rd 1FFFF", d[1], rx);
    send(8'h00);
    chk("rd wrap", d[2], rx);
    u_sfs_spi_master.desel();
    mem_op(8'h0B, 17'h00001);
    send(8'h00);
    send(8'h00);
    chk("fast rd", d[3], rx);
    u_sfs_spi_master.desel();
    $display("test burst done");
    oe_mark = oe_cnt;
    frame(8'hFF);
    send(8'h06);
    send(8'h05);
    u_sfs_spi_master.desel();
    chk("bad op oe", 8'h00, 8'(oe_cnt - oe_mark));
    rd_status(8'h40);
    for (int i = 0; i < 10; i++) begin
      cmd1(ops[i]);
      chk("opcode", ops[i], cmd_ff);
    end
    $display("test opcodes done");
    conclude();
  end
endmodule
